/* rtl/io_cmd_pkg.sv */
package io_cmd_pkg;

    // Timing base
    localparam int CLK_NS = 8;
    localparam int LINK_NS = 80;
    localparam int MEM_CYCLE_NS = 1750;
    localparam int T_PER_CYCLE = 8;
    localparam int QUERY_PULSE_NS = 110;
    // Longest step rounds down, least pulse width rounds up
    localparam int T_STEP_CYC = MEM_CYCLE_NS / (T_PER_CYCLE * CLK_NS);
    localparam int LINK_T_STEP_CYC = MEM_CYCLE_NS / (T_PER_CYCLE * LINK_NS);
    localparam int QUERY_PULSE_LINK_CYC = (QUERY_PULSE_NS + LINK_NS - 1) / LINK_NS;
    localparam logic [4:0] T_STEP_LAST = 5'(T_STEP_CYC - 1);
    localparam logic [3:0] LINK_T_STEP_LAST = 4'(LINK_T_STEP_CYC - 1);
    localparam logic [3:0] QUERY_PULSE_LAST = 4'(QUERY_PULSE_LINK_CYC - 1);

    // Phase indices within a memory cycle (T1 is index 0)
    localparam logic [2:0] T1_IDX = 3'h0;
    localparam logic [2:0] T2_IDX = 3'h1;
    localparam logic [2:0] T4_IDX = 3'h3;
    localparam logic [2:0] T8_IDX = 3'h7;

    // First instruction word
    // Unit code kept clear of the mode flags, so all 64 units work in every mode
    localparam int W1_UNIT_LSB = 10;
    localparam int UNIT_W = 6;
    localparam int W1_INDIRECT_BIT = 5;
    localparam int W1_MAP_BIT = 6;
    localparam int W1_WAIT_BIT = 9;

    // Indirect address word
    localparam int IW_INDEX_BIT = 0;
    localparam int IW_INDIRECT_BIT = 1;
    localparam int IW_ADDR_LSB = 2;
    localparam int IW_ADDR_W = 14;
    localparam int ADDR_W = 15;

    // Function word fields, decoded by the unit
    localparam int FN_BTC_INIT_BIT = 0;
    localparam int FN_INT_VALUE_BIT = 1;
    localparam int FN_INT_SEL_LSB = 2;
    localparam int FN_CODE_LSB = 4;
    localparam int FN_TAPE_LSB = 10;
    localparam int FN_STORE_ADDR_BIT = 13;
    localparam int FN_CHARS_LSB = 14;

    localparam logic [15:0] WORD_RESET = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ARM, ST_I1, ST_I2, ST_E1, ST_XFER, ST_DROP, ST_DONE
    } cmd_state_e;

endpackage : io_cmd_pkg

/* rtl/level_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int WIDTH = 1
) (
    // Destination clock
    input wire logic clk,
    input wire logic arst_n,
    // Levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : level_sync
`default_nettype wire

/* rtl/unit_clock_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module unit_clock_gen (
    // Link clock
    input wire logic link_clk,
    input wire logic arst_n,
    // Query pulses
    output logic unit_clk
);
    logic [3:0] t_cnt;
    logic [2:0] t_idx;
    wire step_end = (t_cnt == io_cmd_pkg::LINK_T_STEP_LAST);
    wire in_query = (t_idx == io_cmd_pkg::T2_IDX) || (t_idx == io_cmd_pkg::T8_IDX);
    wire next_unit_clk = in_query && (t_cnt <= io_cmd_pkg::QUERY_PULSE_LAST);

    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            t_cnt <= 4'h0;
            t_idx <= 3'h0;
            unit_clk <= 1'b0;
        end
        else
        begin
            t_cnt <= step_end ? 4'h0 : t_cnt + 4'h1;
            t_idx <= step_end ? t_idx + 3'h1 : t_idx;
            // (RL23) T2 or T8 pulse
            unit_clk <= next_unit_clk;
        end
    end

    property p_pulse_width;
        @(posedge link_clk) disable iff (!arst_n)
        $rose(unit_clk) |-> unit_clk [*2] ##1 !unit_clk;
    endproperty
    a_query_pulse_width: assert property (p_pulse_width) // RL23
        else $error("query pulse width wrong");
endmodule : unit_clock_gen
`default_nettype wire

/* rtl/io_unit_command_handshake.sv */
// Operation
// (RL1) Wait flag bit 9: unit withholds sync return until ready; computer stalls.
// (RL2) While stalled waiting, only power-fail or stall-alarm interrupts are allowed.
// (RL3) First-word bit 5: zero immediate operand, one indirect address word.
// (RL4) Indirect word: 14-bit address, chain flag bit 1, index flag bit 0.
// (RL5) Bit 6 appends program register MSB as address bit; otherwise zero.
// (RL6) Word ending an indirect chain is the function word, as immediate.
// (RL7) Function bits: 0 counter init, 1 interrupt value, 2-3 interrupt select.
// (RL8) Bits 4-9 function code, 10-12 tape unit, 13 store address, 14-15 characters.
// (RL9) Memory cycles of 1.75 us; at least two I cycles and one E; here eight 216 ns steps, 1.728 us.
// (RL10) Second I cycle tests readiness, repeats in wait; indirect fetch overlaps.
// (RL11) Enter E1 only with function word fetched and unit sync returned.
// (RL12) Command enable, wait flag, unit number steady from T1 to next T1.
// (RL13) At T4 of first I cycle assert instruction sync and hold latch.
// (RL14) Ready unit gates next query pulse into latch driving both returns.
// (RL15) Unit sync return clears the hold latch and advances into E1.
// (RL16) Test return: program register advances twice; else once, no data strobe.
// (RL17) Not ready with wait flag: unit keeps testing; computer stays in I.
// (RL18) Not ready without wait flag: sync return raised, test return low.
// (RL19) Unit clears both returns when instruction sync is removed.
// (RL20) After test return, data-here strobe accompanies function word on data lines.
// (RL21) On data-here, unit captures function bits and raises data accepted.
// (RL22) Data-here held until accepted; unit drops accepted after data-here falls.
// (RL23) Unit clock carries OR of T2 and T8 pulses, each 110 ns; here each pulse is two link cycles, 160 ns.
// (RL24) Six unit code lines always driven during each instruction.
// (RL25) Reset clears all handshake latches; no return level persists.
`timescale 1ns/1ps
`default_nettype none
module io_unit_command_handshake (
    // Clocks and reset
    input wire logic core_clk,
    input wire logic link_clk,
    input wire logic arst_n,
    input wire logic ce,
    // Instruction from the control unit
    input wire logic start,
    input wire logic [15:0] first_word,
    input wire logic [15:0] second_word,
    input wire logic pr_msb,
    input wire logic [14:0] index_value,
    output logic busy,
    output logic wait_stall,
    output logic pr_advance,
    output logic pr_skip,
    output logic done,
    // Indirect fetch port
    output logic mem_req,
    output logic [14:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // Unit bus
    output logic unit_clk,
    output logic cmd_instr,
    output logic wait_level,
    output logic [5:0] unit_code,
    output logic instr_sync,
    output logic data_here,
    output logic [15:0] io_data,
    input wire logic test_return,
    input wire logic sync_return,
    input wire logic data_accepted
);
    io_cmd_pkg::cmd_state_e state;
    logic [4:0] t_cnt;
    logic [2:0] t_idx;
    logic [15:0] word1;
    logic [15:0] fn_word;
    logic fn_ready;
    logic fetch_active;
    logic [14:0] fetch_addr;
    logic fetch_chain;
    logic utr_seen;
    logic usr_seen;
    logic is_req;
    logic cdh_req;
    logic cmd_hold;
    logic [2:0] ret_s;
    logic [1:0] req_link;

    wire utr_s = ret_s[0];
    wire usr_s = ret_s[1];
    wire uda_s = ret_s[2];
    wire step_end = (t_cnt == io_cmd_pkg::T_STEP_LAST);
    wire cycle_end = step_end && (t_idx == io_cmd_pkg::T8_IDX);
    wire t4_start = (t_cnt == 5'h00) && (t_idx == io_cmd_pkg::T4_IDX);
    wire wflag = word1[io_cmd_pkg::W1_WAIT_BIT];
    wire indirect = word1[io_cmd_pkg::W1_INDIRECT_BIT];
    wire map_high = word1[io_cmd_pkg::W1_MAP_BIT];
    // (RL5) High page bit from program register or zero
    wire page_bit = map_high & pr_msb;
    // (RL4) Address source: first fetch from second word, then chained words
    wire [15:0] addr_word = fetch_active ? mem_rdata : second_word;
    wire [14:0] addr_base = {page_bit, addr_word[io_cmd_pkg::IW_ADDR_LSB +: io_cmd_pkg::IW_ADDR_W]};
    wire [14:0] addr_index = addr_word[io_cmd_pkg::IW_INDEX_BIT] ? index_value : 15'h0000;
    wire [14:0] next_addr = addr_base + addr_index;
    // Flag of the addressing word, not of the fetched word, says what comes back
    wire next_chain = addr_word[io_cmd_pkg::IW_INDIRECT_BIT];
    wire go_e1 = (state == io_cmd_pkg::ST_I2) && cycle_end && usr_seen && fn_ready;

    assign busy = (state != io_cmd_pkg::ST_IDLE);
    assign mem_req = fetch_active;
    assign mem_addr = fetch_addr;
    assign cmd_instr = cmd_hold;
    // (RL12) Held from the captured first word until the next instruction
    assign wait_level = wflag;
    // (RL24) Unit code always driven from the held word
    assign unit_code = word1[io_cmd_pkg::W1_UNIT_LSB +: io_cmd_pkg::UNIT_W];
    // (RL2) Interrupts other than power-fail and stall alarm held off
    assign wait_stall = (state == io_cmd_pkg::ST_I2) && wflag && !usr_seen;

    // Unit returns are asynchronous to the core
    level_sync #(.WIDTH(3)) u_ret_sync (
        .clk(core_clk),
        .arst_n(arst_n),
        .d({data_accepted, sync_return, test_return}),
        .q(ret_s)
    );

    // (RL9) Eight T steps per cycle
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            t_cnt <= 5'h00;
            t_idx <= io_cmd_pkg::T1_IDX;
        end
        else if (ce)
        begin
            t_cnt <= step_end ? 5'h00 : t_cnt + 5'h01;
            t_idx <= step_end ? t_idx + 3'h1 : t_idx;
        end
    end

    // (RL25) Every latch returns to zero on reset
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= io_cmd_pkg::ST_IDLE;
            word1 <= io_cmd_pkg::WORD_RESET;
            fn_word <= io_cmd_pkg::WORD_RESET;
            io_data <= io_cmd_pkg::WORD_RESET;
            fn_ready <= 1'b0;
            fetch_active <= 1'b0;
            fetch_addr <= 15'h0000;
            fetch_chain <= 1'b0;
            utr_seen <= 1'b0;
            usr_seen <= 1'b0;
            is_req <= 1'b0;
            cdh_req <= 1'b0;
            cmd_hold <= 1'b0;
            pr_advance <= 1'b0;
            pr_skip <= 1'b0;
            done <= 1'b0;
        end
        else if (ce)
        begin
            pr_advance <= 1'b0;
            done <= 1'b0;
            // (RL10) Indirect chain runs alongside the readiness test
            if (fetch_active && mem_ack)
            begin
                if (fetch_chain)
                begin
                    fetch_addr <= next_addr;
                    fetch_chain <= next_chain;
                end
                else
                begin
                    // (RL6) Chain end word becomes the function word
                    fn_word <= mem_rdata;
                    fn_ready <= 1'b1;
                    fetch_active <= 1'b0;
                end
            end
            unique case (state)
                io_cmd_pkg::ST_IDLE:
                begin
                    if (start)
                    begin
                        word1 <= first_word;
                        fn_ready <= 1'b0;
                        utr_seen <= 1'b0;
                        usr_seen <= 1'b0;
                        state <= io_cmd_pkg::ST_ARM;
                    end
                end
                io_cmd_pkg::ST_ARM:
                begin
                    if (cycle_end)
                    begin
                        cmd_hold <= 1'b1;
                        state <= io_cmd_pkg::ST_I1;
                    end
                end
                io_cmd_pkg::ST_I1:
                begin
                    // (RL13) Instruction sync and hold latch at T4
                    is_req <= is_req || t4_start;
                    if (cycle_end)
                    begin
                        state <= io_cmd_pkg::ST_I2;
                        // (RL3) Address mode fetches, immediate uses second word
                        if (indirect)
                        begin
                            fetch_active <= 1'b1;
                            fetch_addr <= next_addr;
                            fetch_chain <= next_chain;
                        end
                        else
                        begin
                            fn_word <= second_word;
                            fn_ready <= 1'b1;
                        end
                    end
                end
                io_cmd_pkg::ST_I2:
                begin
                    // (RL14) Test return may lag sync return by a sync stage
                    utr_seen <= utr_seen || utr_s;
                    // (RL15) Sync return releases the hold latch
                    if (usr_s)
                    begin
                        usr_seen <= 1'b1;
                        is_req <= 1'b0;
                    end
                    // (RL11) Both conditions before E1
                    if (go_e1)
                    begin
                        io_data <= fn_word;
                        // (RL20) Data strobe only after test return
                        cdh_req <= utr_seen;
                        state <= io_cmd_pkg::ST_E1;
                    end
                end
                io_cmd_pkg::ST_E1:
                begin
                    if (cycle_end)
                    begin
                        state <= utr_seen ? io_cmd_pkg::ST_XFER : io_cmd_pkg::ST_DONE;
                        pr_advance <= !utr_seen;
                        pr_skip <= 1'b0;
                        done <= !utr_seen;
                    end
                end
                io_cmd_pkg::ST_XFER:
                begin
                    // (RL22) Strobe held until accepted
                    if (uda_s)
                    begin
                        cdh_req <= 1'b0;
                        state <= io_cmd_pkg::ST_DROP;
                    end
                end
                io_cmd_pkg::ST_DROP:
                begin
                    if (!uda_s)
                    begin
                        // (RL16) Test return gives a double advance
                        pr_advance <= 1'b1;
                        pr_skip <= 1'b1;
                        done <= 1'b1;
                        state <= io_cmd_pkg::ST_DONE;
                    end
                end
                io_cmd_pkg::ST_DONE:
                begin
                    // Command enable dropped at the T1 that ends the done cycle
                    if (cycle_end)
                    begin
                        cmd_hold <= 1'b0;
                        state <= io_cmd_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Link side: sync and data-here levels launched on the link clock
    level_sync #(.WIDTH(2)) u_req_sync (
        .clk(link_clk),
        .arst_n(arst_n),
        .d({cdh_req, is_req}),
        .q(req_link)
    );

    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            instr_sync <= 1'b0;
            data_here <= 1'b0;
        end
        else
        begin
            instr_sync <= req_link[0];
            data_here <= req_link[1];
        end
    end

    unit_clock_gen u_unit_clk (
        .link_clk(link_clk),
        .arst_n(arst_n),
        .unit_clk(unit_clk)
    );

    sequence s_accepted;
        cdh_req && uda_s && ce && state == io_cmd_pkg::ST_XFER;
    endsequence

    a_sync_at_t4: assert property (@(posedge core_clk) disable iff (!arst_n) // RL13
        $rose(is_req) |-> $past(t4_start) && $past(state) == io_cmd_pkg::ST_I1)
        else $error("instruction sync not raised at T4");
    a_e1_gating: assert property (@(posedge core_clk) disable iff (!arst_n) // RL11
        $rose(state == io_cmd_pkg::ST_E1) |-> $past(fn_ready) && $past(usr_seen))
        else $error("E1 entered before word or sync return");
    a_hold_release: assert property (@(posedge core_clk) disable iff (!arst_n) // RL15
        $fell(is_req) |-> $past(usr_s) && state == io_cmd_pkg::ST_I2)
        else $error("hold latch released without sync return");
    a_no_strobe_skip: assert property (@(posedge core_clk) disable iff (!arst_n) // RL20
        cdh_req |-> utr_seen && io_data == fn_word)
        else $error("data strobe without test return");
    a_strobe_held: assert property (@(posedge core_clk) disable iff (!arst_n) // RL22
        cdh_req && !uda_s |=> cdh_req)
        else $error("data strobe dropped before accepted");
    a_strobe_drop: assert property (@(posedge core_clk) disable iff (!arst_n) // RL22
        s_accepted |=> !cdh_req ##0 state == io_cmd_pkg::ST_DROP)
        else $error("data strobe not removed after accept");
    a_advance_count: assert property (@(posedge core_clk) disable iff (!arst_n) // RL16
        pr_advance && ce |-> pr_skip == utr_seen)
        else $error("program advance count wrong");
    a_fields_steady: assert property (@(posedge core_clk) disable iff (!arst_n) // RL12
        cmd_hold && $past(cmd_hold) |-> $stable(unit_code) && $stable(wait_level))
        else $error("held instruction fields changed");
    a_wait_stall: assert property (@(posedge core_clk) disable iff (!arst_n) // RL1
        wait_stall && cycle_end && ce |=> state == io_cmd_pkg::ST_I2)
        else $error("wait cycle left without sync return");
    a_map_page: assert property (@(posedge core_clk) disable iff (!arst_n) // RL5
        busy && !map_high |-> addr_base[14] == 1'b0)
        else $error("page bit set without map flag");
endmodule : io_unit_command_handshake
`default_nettype wire

/* verification/unit_terminal_model.sv */
`timescale 1ns/1ps
`default_nettype none
module unit_terminal_model (
    // Bus from the computer
    input wire logic arst_n,
    input wire logic unit_clk,
    input wire logic instr_sync,
    input wire logic cmd_instr,
    input wire logic wait_level,
    input wire logic [5:0] unit_code,
    input wire logic data_here,
    input wire logic [15:0] io_data,
    // Unit state set by the bench
    input wire logic [5:0] my_code,
    input wire logic unit_ready,
    input wire logic slow,
    // Returns to the computer
    output logic test_return,
    output logic sync_return,
    output logic data_accepted,
    output logic [15:0] fn_word
);
    logic selected;
    logic [1:0] hold;

    assign selected = instr_sync && cmd_instr && (unit_code == my_code);

    always @(posedge unit_clk or negedge arst_n or negedge instr_sync)
        if (!arst_n || !instr_sync)
        begin
            test_return <= 1'b0;
            sync_return <= 1'b0;
        end
        else if (selected && unit_ready)
        begin
            test_return <= 1'b1;
            sync_return <= 1'b1;
        end
        else if (selected && !wait_level)
            sync_return <= 1'b1;

    always @(posedge unit_clk or negedge arst_n or negedge data_here)
        if (!arst_n || !data_here)
        begin
            data_accepted <= 1'b0;
            hold <= slow ? 2'h2 : 2'h0;
            if (!arst_n)
                fn_word <= 16'h0000;
        end
        else if (hold != 2'h0)
            hold <= hold - 2'h1;
        else if (!data_accepted)
        begin
            fn_word <= io_data;
            data_accepted <= 1'b1;
        end
endmodule : unit_terminal_model
`default_nettype wire

/* verification/io_unit_command_handshake_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module io_unit_command_handshake_tb_top;
    typedef struct packed {logic skip; logic [5:0] code; logic [15:0] fn;} note_s;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic arst_n, ce, start, pr_msb, mem_ack, unit_ready, slow;
    logic [15:0] first_word, second_word, mem_rdata;
    logic [14:0] index_value;
    logic [5:0] my_code;
    logic busy, wait_stall, pr_advance, pr_skip, done, mem_req, unit_clk, cmd_instr;
    logic wait_level, instr_sync, data_here, test_return, sync_return, data_accepted;
    logic [14:0] mem_addr;
    logic [5:0] unit_code;
    logic [15:0] io_data, fn_word, r;
    int errors = 0;
    int cmp_count = 0;
    int seed = 95;
    int dh_cnt = 0;
    int elapsed = 0;
    int lat = 0;
    logic dh_prev = 1'b0;
    logic acc_seen = 1'b0;
    note_s notes[$];
    note_s mon;
    logic [14:0] addr_q[$];
    logic [15:0] mem [logic [14:0]];

    always #4 core_clk = ~core_clk;
    initial
    begin
        #3;
        forever #40 link_clk = ~link_clk;
    end

    io_unit_command_handshake dut (
        .core_clk(core_clk), .link_clk(link_clk), .arst_n(arst_n), .ce(ce),
        .start(start), .first_word(first_word), .second_word(second_word),
        .pr_msb(pr_msb), .index_value(index_value), .busy(busy), .wait_stall(wait_stall),
        .pr_advance(pr_advance), .pr_skip(pr_skip), .done(done), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .unit_clk(unit_clk),
        .cmd_instr(cmd_instr), .wait_level(wait_level), .unit_code(unit_code),
        .instr_sync(instr_sync), .data_here(data_here), .io_data(io_data),
        .test_return(test_return), .sync_return(sync_return), .data_accepted(data_accepted)
    );

    unit_terminal_model unit (
        .arst_n(arst_n), .unit_clk(unit_clk), .instr_sync(instr_sync),
        .cmd_instr(cmd_instr), .wait_level(wait_level), .unit_code(unit_code),
        .data_here(data_here), .io_data(io_data), .my_code(my_code),
        .unit_ready(unit_ready), .slow(slow), .test_return(test_return),
        .sync_return(sync_return), .data_accepted(data_accepted), .fn_word(fn_word)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // Expected result noted first; the monitor pairs it with done
    task automatic run_instr(input logic [15:0] w1, input logic [15:0] w2, input logic rdy,
                             input int rdy_delay, input logic [15:0] exp_fn);
        note_s n;
        int k;
        n.skip = rdy;
        n.code = w1[15:10];
        n.fn = exp_fn;
        notes.push_back(n);
        @(negedge core_clk);
        first_word = w1;
        second_word = w2;
        my_code = w1[15:10];
        unit_ready = rdy && (rdy_delay == 0);
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        if (rdy_delay > 0)
        begin
            repeat (rdy_delay) @(negedge core_clk);
            check(wait_stall, 1'b1);
            check(pr_advance, 1'b0);
            unit_ready = 1'b1;
        end
        k = 0;
        while (busy !== 1'b0 && k < 20000)
        begin
            @(negedge core_clk);
            k++;
        end
        check(busy, 1'b0);
    endtask : run_instr

    // Result monitor
    always @(negedge core_clk)
        if (arst_n)
        begin
            elapsed = busy ? elapsed + 1 : 0;
            if (data_here && !dh_prev)
                dh_cnt++;
            if (data_here && data_accepted)
                acc_seen = 1'b1;
            if (dh_prev && !data_here)
                check(acc_seen, 1'b1);
            dh_prev = data_here;
            if (done === 1'b1 && notes.size() > 0)
            begin
                mon = notes.pop_front();
                check(pr_advance, 1'b1);
                check(pr_skip, mon.skip);
                check(dh_cnt, mon.skip);
                check({cmd_instr, unit_code}, {1'b1, mon.code});
                check(elapsed >= 3 * 216, 1'b1);
                if (mon.skip)
                    check(fn_word, mon.fn);
                dh_cnt = 0;
                acc_seen = 1'b0;
            end
        end

    // Memory for indirect fetches; released data toggles
    always @(negedge core_clk)
        if (mem_req === 1'b1 && !mem_ack)
        begin
            if (lat > 0)
                lat--;
            else
            begin
                check(mem_addr, addr_q.pop_front());
                mem_ack = 1'b1;
                mem_rdata = mem[mem_addr];
                lat = $random(seed) & 3;
            end
        end
        else
        begin
            mem_ack = 1'b0;
            mem_rdata = ~mem_rdata;
        end

    initial
    begin
        repeat (60000) @(posedge core_clk);
        errors++;
        test_done();
    end

    initial
    begin
        arst_n = 1'b0;
        ce = 1'b1;
        start = 1'b0;
        first_word = 16'h0000;
        second_word = 16'h0000;
        pr_msb = 1'b1;
        index_value = 15'h0011;
        mem_ack = 1'b0;
        mem_rdata = 16'h0000;
        unit_ready = 1'b0;
        slow = 1'b0;
        my_code = 6'h00;
        repeat (10) @(negedge core_clk);
        arst_n = 1'b1;
        check({busy, cmd_instr, instr_sync, data_here, done, mem_req}, 6'h00);
        mem[15'h4123] = 16'h0801;
        mem[15'h4211] = 16'hA5C3;
        mem[15'h3FFF] = 16'h5A3C;
        run_instr(16'h5400, 16'h3C5A, 1'b1, 0, 16'h3C5A);
        run_instr(16'h5400, 16'h1234, 1'b0, 0, 16'h0000);
        slow = 1'b1;
        run_instr(16'h5600, 16'h0F0F, 1'b1, 1000, 16'h0F0F);
        addr_q.push_back(15'h4123);
        addr_q.push_back(15'h4211);
        run_instr(16'hA860, 16'h048E, 1'b1, 0, 16'hA5C3);
        addr_q.push_back(15'h3FFF);
        run_instr(16'h8420, 16'hFFFC, 1'b1, 0, 16'h5A3C);
        repeat (6)
        begin
            r = 16'($random(seed));
            slow = r[15];
            run_instr(r & 16'hFD9F, ~r, r[14], 0, ~r);
        end
        // Reset in mid-instruction must clear every latch
        unit_ready = 1'b1;
        first_word = 16'h5400;
        my_code = 6'h15;
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        repeat (400) @(negedge core_clk);
        arst_n = 1'b0;
        repeat (30) @(negedge core_clk);
        check({instr_sync, test_return, sync_return, data_accepted, busy}, 5'h00);
        arst_n = 1'b1;
        run_instr(16'h5400, 16'h3C5A, 1'b1, 0, 16'h3C5A);
        check(notes.size(), 0);
        test_done();
    end
endmodule : io_unit_command_handshake_tb_top
`default_nettype wire
